// ==== include/keypad_menu_cfg.svh ====
// Timing counts, menu sizes, digit layout and unlock sequence for the keypad menu controller.
// Assumes a 10 MHz system clock; included by its bare name.
`ifndef KEYPAD_MENU_CFG_SVH
`define KEYPAD_MENU_CFG_SVH
`define CLK_HZ 10000000
`define HOLD_MS 3000
`define HOLD_CYC ((`CLK_HZ / 1000) * `HOLD_MS)
`define IDLE_MS 10000
`define IDLE_CYC ((`CLK_HZ / 1000) * `IDLE_MS)
`define DEB_US 10000
`define DEB_CYC ((`CLK_HZ / 1000000) * `DEB_US)
`define STEP_MS 300
`define STEP_CYC ((`CLK_HZ / 1000) * `STEP_MS)
`define NDIG 6
`define BASIC_ITEMS 5'h09
`define OPER_ITEMS 5'h10
`define LIN_ITEMS 6'h20
`define LIN_ITEM 4'h8
`define CODE_ITEM 4'h7
`define UNLOCK_LEN 3'h5
`define UNLOCK_SEQ 15'h4A52
`define LOCK_NONE 2'h0
`define LOCK_ALL 2'h1
`define LOCK_PFREE 2'h2
`define DIG_MINUS 4'hA
`define DIG_MINUS1 4'hB
`endif

// ==== include/keypad_menu_pkg.sv ====
// Types used by the keypad menu controller; the bench does not import them.
// No assumptions beyond a SystemVerilog compiler.
package keypad_menu_pkg;
  typedef enum logic [2:0] {ST_NORMAL, ST_LOCKED, ST_BASIC, ST_OPER, ST_TEACH} menu_state_t;
  typedef logic [3:0] digit_t;
endpackage

// ==== rtl/keypad_menu_controller.sv ====
// Keypad and menu state machine for a position indicator with three front keys.
// Assumes keys are synchronous, active high, and that a parameter store answers commits.
`include "keypad_menu_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

// Function
// - Leave normal display only from normal display
// - Enter plus set held 3 s: basic setup
// - Enter alone held 3 s: operational setup
// - Command held 3 s: teach operation
// - Command key used only for teach and the unlock sequence
// - Enter advances item, set starts editing
// - Enter while editing commits then advances
// - Editing starts on blinking least digit
// - Held set steps digit 0 to 9
// - Set release keeps digit, moves up
// - Pointer wraps from top to least digit
// - Signed top digit adds minus, minus one
// - Enter held 3 s returns to display
// - 10 s idle leaves menu, discards edit
// - No idle timeout during teach
// - Enter ends or aborts teach
// - Set edits in teach like setup
// - Command stores point then advances
// - Enter held at power-up restores defaults
// - Locked keypad needs sequence within 10 s
// - Menu skips items of disabled functions
// - Point pairs shown only with linearization
// - Lock setting has three values
module keypad_menu_controller
  import keypad_menu_pkg::*;
#(
  parameter int HOLD_CYC = `HOLD_CYC,
  parameter int IDLE_CYC = `IDLE_CYC,
  parameter int DEB_CYC = `DEB_CYC,
  parameter int STEP_CYC = `STEP_CYC
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic key_enter_i,
  input wire logic key_set_i,
  input wire logic key_cmd_i,
  input wire logic [1:0] lock_mode_i,
  input wire logic lin_enable_i,
  input wire logic item_signed_i,
  input wire logic [23:0] load_value_i,
  input wire logic [23:0] display_value_i,
  output logic [2:0] state_o,
  output logic [5:0] item_o,
  output logic editing_o,
  output logic [2:0] active_digit_o,
  output logic [23:0] edit_value_o,
  output logic commit_o,
  output logic [5:0] commit_item_o,
  output logic basic_menu_o,
  output logic teach_store_o,
  output logic [3:0] teach_point_o,
  output logic restore_defaults_o,
  output logic lock_prompt_o
);

  menu_state_t state;
  logic [2:0] deb_q;
  logic [2:0] deb_prev;
  logic [23:0] deb_cnt [3];
  logic [31:0] hold_cnt;
  logic [2:0] hold_combo;
  logic [31:0] idle_cnt;
  logic [31:0] step_cnt;
  logic [2:0] seq_idx;
  logic first_cycle;
  logic [2:0] raw;
  logic [2:0] press;
  logic [2:0] rel;
  logic hold_done;
  logic idle_done;
  logic step_tick;
  logic in_menu;
  logic [5:0] item_limit;
  logic [5:0] next_item;
  digit_t cur_digit;
  digit_t next_digit;
  logic [2:0] exp_key;

  assign raw = {key_cmd_i, key_set_i, key_enter_i};

  // Debounce each key: a change must persist DEB_CYC cycles before it is taken
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_deb
      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          deb_cnt[g] <= 24'h000000;
          deb_q[g] <= 1'b0;
        end else if (raw[g] == deb_q[g]) begin
          deb_cnt[g] <= 24'h000000;
        end else if (deb_cnt[g] >= 24'(DEB_CYC - 1)) begin
          deb_q[g] <= raw[g];
          deb_cnt[g] <= 24'h000000;
        end else begin
          deb_cnt[g] <= deb_cnt[g] + 24'h000001;
        end
      end
    end
  endgenerate

  // Edge and timer decodes
  assign press = deb_q & ~deb_prev;
  assign rel = ~deb_q & deb_prev;
  assign hold_done = (deb_q != 3'b000) && (hold_cnt == 32'(HOLD_CYC - 1));
  assign idle_done = (idle_cnt == 32'(IDLE_CYC - 1));
  assign step_tick = deb_q[1] && (step_cnt == 32'(STEP_CYC - 1));
  assign in_menu = (state == ST_BASIC) || (state == ST_OPER);
  // Point pairs only appear past the fixed operational items when enabled
  assign item_limit = (state == ST_BASIC) ? 6'(`BASIC_ITEMS) :
                      (lin_enable_i ? 6'(`OPER_ITEMS) + `LIN_ITEMS : 6'(`OPER_ITEMS));
  assign next_item = (item_o + 6'h01 >= item_limit) ? 6'h00 : item_o + 6'h01;
  assign cur_digit = edit_value_o[active_digit_o*4 +: 4];
  assign exp_key = 3'(`UNLOCK_SEQ >> (seq_idx * 3)) & 3'b111;

  // Digit stepping: signed top digit runs 0..9, minus, minus one
  function automatic digit_t step_digit(input digit_t d, input logic top_signed);
    if (top_signed && d == 4'h9) return `DIG_MINUS;
    if (top_signed && d == `DIG_MINUS) return `DIG_MINUS1;
    if (d >= 4'h9) return 4'h0;
    return d + 4'h1;
  endfunction
  assign next_digit = step_digit(cur_digit, item_signed_i && active_digit_o == 3'(`NDIG - 1));

  // Hold timer follows one key combination; any change or release restarts it
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      hold_cnt <= 32'h00000000;
      hold_combo <= 3'b000;
      deb_prev <= 3'b000;
    end else begin
      deb_prev <= deb_q;
      hold_combo <= deb_q;
      if (deb_q != hold_combo || deb_q == 3'b000 || hold_done)
        hold_cnt <= 32'h00000000;
      else
        hold_cnt <= hold_cnt + 32'h00000001;
    end
  end

  // Idle and auto-repeat counters; idle halted in teach
  always_ff @(posedge clk_i) begin
    if (srst_i || deb_q != 3'b000 || state == ST_TEACH || state == ST_NORMAL)
      idle_cnt <= 32'h00000000;
    else
      idle_cnt <= idle_cnt + 32'h00000001;
    if (srst_i || !deb_q[1] || step_tick)
      step_cnt <= 32'h00000000;
    else
      step_cnt <= step_cnt + 32'h00000001;
  end

  // Main menu state machine
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state <= ST_NORMAL;
      item_o <= 6'h00;
      editing_o <= 1'b0;
      active_digit_o <= 3'h0;
      edit_value_o <= 24'h000000;
      commit_o <= 1'b0;
      commit_item_o <= 6'h00;
      teach_store_o <= 1'b0;
      teach_point_o <= 4'h0;
      restore_defaults_o <= 1'b0;
      seq_idx <= 3'h0;
      first_cycle <= 1'b1;
    end else begin
      commit_o <= 1'b0;
      teach_store_o <= 1'b0;
      restore_defaults_o <= 1'b0;
      first_cycle <= 1'b0;
      // Raw key sampled at the first edge after reset, before debounce settles
      if (first_cycle && key_enter_i)
        restore_defaults_o <= 1'b1;
      case (state)
        ST_NORMAL: begin
          seq_idx <= 3'h0;
          // Lock prompt on any press when locking is set; every value but NONE locks
          if (press != 3'b000 && lock_mode_i != `LOCK_NONE && !first_cycle)
            state <= ST_LOCKED;
          else if (hold_done && hold_combo == 3'b011)
            state <= ST_BASIC;
          else if (hold_done && hold_combo == 3'b001)
            state <= ST_OPER;
          else if (hold_done && hold_combo == 3'b100)
            state <= ST_TEACH;
          item_o <= 6'h00;
          editing_o <= 1'b0;
          teach_point_o <= 4'h0;
        end
        ST_LOCKED: begin
          if (idle_done)
            state <= ST_NORMAL;
          else if (press != 3'b000) begin
            if (press != exp_key)
              seq_idx <= 3'h0;
            else if (seq_idx == `UNLOCK_LEN - 3'h1) begin
              state <= ST_NORMAL;
              seq_idx <= 3'h0;
            end else
              seq_idx <= seq_idx + 3'h1;
          end
        end
        ST_BASIC, ST_OPER, ST_TEACH: begin
          if (hold_done && hold_combo == 3'b001) begin
            state <= ST_NORMAL;
            editing_o <= 1'b0;
          end else if (idle_done && in_menu) begin
            state <= ST_NORMAL;
            editing_o <= 1'b0;
          end else if (press[0] && state == ST_TEACH) begin
            state <= ST_NORMAL;
            editing_o <= 1'b0;
          end else if (press[2] && state == ST_TEACH) begin
            teach_store_o <= 1'b1;
            edit_value_o <= display_value_i;
            teach_point_o <= teach_point_o + 4'h1;
          end else if (press[0]) begin
            if (editing_o) begin
              commit_o <= 1'b1;
              commit_item_o <= item_o;
            end
            editing_o <= 1'b0;
            item_o <= next_item;
          end else if (press[1] && !editing_o) begin
            editing_o <= 1'b1;
            edit_value_o <= (state == ST_TEACH) ? display_value_i : load_value_i;
            active_digit_o <= 3'h0;
          end else if (editing_o && step_tick) begin
            edit_value_o[active_digit_o*4 +: 4] <= next_digit;
          end else if (editing_o && rel[1]) begin
            active_digit_o <= (active_digit_o == 3'(`NDIG - 1)) ? 3'h0
                              : active_digit_o + 3'h1;
          end
        end
        default: state <= ST_NORMAL;
      endcase
    end
  end

  // Registered status views
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_o <= 3'h0;
      basic_menu_o <= 1'b0;
      lock_prompt_o <= 1'b0;
    end else begin
      state_o <= state;
      basic_menu_o <= (state == ST_BASIC);
      lock_prompt_o <= (state == ST_LOCKED);
    end
  end

endmodule
`default_nettype wire

// ==== tb/keypad_menu_checker.sv ====
// Assertions for the keypad menu controller, bound to its top module.
// Sees top ports only; counts use raw keys, which lead the debounced ones.
`timescale 1ns/10ps
`default_nettype none
module keypad_menu_checker #(parameter int HOLD_CYC = 20, parameter int IDLE_CYC = 60) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic key_enter_i,
  input wire logic key_set_i,
  input wire logic key_cmd_i,
  input wire logic [2:0] state_o,
  input wire logic editing_o,
  input wire logic [2:0] active_digit_o,
  input wire logic commit_o,
  input wire logic teach_store_o
);
  int n_ent, n_set, n_cmd, n_idle;
  // Raw hold and quiet counts; margins cover the debounce delay
  always_ff @(posedge clk_i) begin
    n_ent <= key_enter_i ? n_ent + 1 : 0;
    n_set <= key_set_i ? n_set + 1 : 0;
    n_cmd <= key_cmd_i ? n_cmd + 1 : 0;
    n_idle <= (key_enter_i | key_set_i | key_cmd_i) ? 0 : n_idle + 1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  hold_entry_a: assert property ($past(state_o) == 3'h0 && state_o inside {3'h2, 3'h3} |-> n_ent >= HOLD_CYC)
    else $error("menu entered on short enter hold");
  basic_both_a: assert property ($past(state_o) == 3'h0 && state_o == 3'h2 |-> n_set >= HOLD_CYC)
    else $error("basic setup without set hold");
  teach_entry_a: assert property ($past(state_o) != 3'h4 && state_o == 3'h4 |-> $past(state_o) == 3'h0 && n_cmd >= HOLD_CYC)
    else $error("teach entered wrongly");
  store_teach_a: assert property (teach_store_o |-> state_o == 3'h4)
    else $error("point stored outside teach");
  edit_start_a: assert property ($rose(editing_o) |-> active_digit_o == 3'h0)
    else $error("edit not on least digit");
  digit_step_a: assert property (editing_o && $past(editing_o) && $changed(active_digit_o) |->
    active_digit_o == ($past(active_digit_o) == 3'h5 ? 3'h0 : $past(active_digit_o) + 3'h1))
    else $error("active digit moved wrongly");
  commit_edit_a: assert property (commit_o |-> $past(editing_o))
    else $error("commit without edit");
  idle_leave_a: assert property (n_idle >= IDLE_CYC + 8 |-> state_o inside {3'h0, 3'h4})
    else $error("idle timeout missed");
  teach_exit_a: assert property ($past(state_o) == 3'h4 && state_o != 3'h4 |-> n_idle < 16)
    else $error("teach left without a key");
  menu_exit_a: assert property ($past(state_o) inside {3'h2, 3'h3} && state_o == 3'h0 |->
    n_ent >= HOLD_CYC || n_idle >= IDLE_CYC - 8)
    else $error("menu left without cause");
  cover property (state_o == 3'h2);
  cover property (teach_store_o);
  cover property (commit_o);
endmodule
bind keypad_menu_controller keypad_menu_checker #(.HOLD_CYC(HOLD_CYC), .IDLE_CYC(IDLE_CYC)) i_keypad_menu_checker (
  .clk_i(clk_i), .srst_i(srst_i), .key_enter_i(key_enter_i), .key_set_i(key_set_i), .key_cmd_i(key_cmd_i),
  .state_o(state_o), .editing_o(editing_o), .active_digit_o(active_digit_o), .commit_o(commit_o),
  .teach_store_o(teach_store_o));
`default_nettype wire

// ==== tb/key_operator.sv ====
// Operator model pressing the three front keys.
// Assumes the bench calls its task; keys change 1 ns after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module key_operator (
  input wire logic clk_i,
  output var logic [2:0] keys_o
);
  // Bit 0 enter, bit 1 set, bit 2 command; all released at start
  initial keys_o = 3'h0;
  // Hold a key combination for n edges, then let go of all keys
  task automatic hold(input logic [2:0] m, input int n);
    @(posedge clk_i);
    #1 keys_o = m;
    repeat (n) @(posedge clk_i);
    #1 keys_o = 3'h0;
  endtask
endmodule
`default_nettype wire

// ==== tb/keypad_menu_controller_tb.sv ====
// Self-checking bench for the keypad menu controller.
// Assumes shortened counts; the operator model drives the keys.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module keypad_menu_controller_tb;
  logic clk_i = 0, srst_i = 1, editing_o, commit_o, basic_menu_o, teach_store_o, restore_defaults_o, lock_prompt_o;
  logic [1:0] lock = 2'h0;
  logic lin = 1'b0, sgn = 1'b0;
  logic [2:0] keys, state_o, active_digit_o;
  logic [5:0] item_o, commit_item_o;
  logic [3:0] teach_point_o;
  logic [23:0] edit_value_o;
  int n_fail = 0, n_tests = 0, n_com = 0, n_sto = 0, n_rst = 0, cyc = 0;
  // Short counts keep the run brief; stored value is fixed BCD
  keypad_menu_controller #(.HOLD_CYC(20), .IDLE_CYC(60), .DEB_CYC(2), .STEP_CYC(5)) i_keypad_menu_controller (
    .clk_i(clk_i), .srst_i(srst_i), .key_enter_i(keys[0]), .key_set_i(keys[1]), .key_cmd_i(keys[2]),
    .lock_mode_i(lock), .lin_enable_i(lin), .item_signed_i(sgn), .load_value_i(24'h987654),
    .display_value_i(24'h000123), .state_o(state_o), .item_o(item_o), .editing_o(editing_o),
    .active_digit_o(active_digit_o), .edit_value_o(edit_value_o), .commit_o(commit_o),
    .commit_item_o(commit_item_o), .basic_menu_o(basic_menu_o), .teach_store_o(teach_store_o),
    .teach_point_o(teach_point_o), .restore_defaults_o(restore_defaults_o), .lock_prompt_o(lock_prompt_o));
  key_operator i_key_operator (.clk_i(clk_i), .keys_o(keys));
  always #50 clk_i = ~clk_i;
  // Pulses are counted so no single cycle is missed; the cycle ceiling cuts hangs
  always @(posedge clk_i) begin
    n_com += commit_o;
    n_sto += teach_store_o;
    n_rst += restore_defaults_o;
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      test_done;
    end
  end
  task automatic wait_st(input logic [2:0] s);
    repeat (12) if (state_o !== s) @(posedge clk_i);
  endtask
  task automatic t_restore;
    fork
      i_key_operator.hold(3'h1, 8);
      begin repeat (5) @(posedge clk_i); #1 srst_i = 0; end
    join
    repeat (4) @(posedge clk_i);
    `CHK("restore", 1, n_rst)
  endtask
  task automatic t_oper;
    i_key_operator.hold(3'h1, 30);
    wait_st(3'h3);
    `CHK("oper", 3'h3, state_o)
    i_key_operator.hold(3'h4, 30);
    repeat (5) @(posedge clk_i);
    `CHK("cmd_ignored", 3'h3, state_o)
    i_key_operator.hold(3'h2, 3);
    repeat (6) @(posedge clk_i);
    `CHK("editing", 1'b1, editing_o)
    `CHK("digit1", 3'h1, active_digit_o)
    `CHK("kept", 20'h98765, edit_value_o[23:4])
    i_key_operator.hold(3'h2, 16);
    repeat (6) @(posedge clk_i);
    `CHK("stepped", 1'b1, edit_value_o[7:4] != 4'h5 && edit_value_o[7:4] <= 4'h9)
    `CHK("digit2", 3'h2, active_digit_o)
    i_key_operator.hold(3'h1, 3);
    repeat (6) @(posedge clk_i);
    `CHK("commits", 1, n_com)
    `CHK("commit_item", 6'h00, commit_item_o)
    `CHK("next_item", 6'h01, item_o)
  endtask
  task automatic t_idle;
    repeat (80) @(posedge clk_i);
    `CHK("timeout", 3'h0, state_o)
  endtask
  task automatic t_basic;
    i_key_operator.hold(3'h3, 30);
    wait_st(3'h2);
    `CHK("basic", 3'h2, state_o)
    `CHK("basic_flag", 1'b1, basic_menu_o)
    i_key_operator.hold(3'h1, 30);
    wait_st(3'h0);
    `CHK("exit", 3'h0, state_o)
  endtask
  task automatic t_teach;
    i_key_operator.hold(3'h4, 30);
    wait_st(3'h4);
    `CHK("teach", 3'h4, state_o)
    repeat (100) @(posedge clk_i);
    `CHK("no_timeout", 3'h4, state_o)
    i_key_operator.hold(3'h4, 3);
    repeat (6) @(posedge clk_i);
    `CHK("stores", 1, n_sto)
    `CHK("point", 4'h1, teach_point_o)
    i_key_operator.hold(3'h1, 3);
    wait_st(3'h0);
    `CHK("teach_end", 3'h0, state_o)
  endtask
  task automatic t_lock;
    for (int m = 1; m < 3; m++) begin
      @(posedge clk_i);
      #1 lock = m[1:0];
      i_key_operator.hold(3'h2, 3);
      repeat (4) @(posedge clk_i);
      `CHK("prompt", 1'b1, lock_prompt_o)
      repeat (80) @(posedge clk_i);
      `CHK("lock_out", 3'h0, state_o)
    end
    #1 lock = 2'h0;
  endtask
  // Point pairs lengthen the operational menu; key gaps exceed the debounce time
  task automatic t_lin;
    @(posedge clk_i);
    #1 lin = 1'b1;
    i_key_operator.hold(3'h1, 30);
    wait_st(3'h3);
    repeat (16) begin
      repeat (4) @(posedge clk_i);
      i_key_operator.hold(3'h1, 3);
    end
    repeat (6) @(posedge clk_i);
    `CHK("lin_items", 6'h10, item_o)
    @(posedge clk_i);
    #1 lin = 1'b0;
    repeat (4) @(posedge clk_i);
    i_key_operator.hold(3'h1, 3);
    repeat (6) @(posedge clk_i);
    `CHK("skip_lin", 6'h00, item_o)
    repeat (80) @(posedge clk_i);
    `CHK("lin_exit", 3'h0, state_o)
  endtask
  task automatic test_done;
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    t_restore;
    t_oper;
    t_idle;
    t_basic;
    t_teach;
    t_lock;
    t_lin;
    test_done;
  end
endmodule
`default_nettype wire
